// ---- irq_pkg.sv ----
package irq_pkg;

	// ********************************
	// source numbering and vectors
	// ********************************
	localparam int NUM_SRC = 13;  // vector slots 0003H to 0063H, reserved slot included
	localparam int SLOT_RESERVED = 10;  // slot at the reserved vector, never requested
	localparam logic [15:0] VEC_RESET = 16'h0000;  // start address after system reset
	localparam logic [15:0] VEC_FIRST = 16'h0003;  // first source vector
	localparam logic [15:0] VEC_STEP = 16'h0008;  // spacing between vector slots
	localparam logic [15:0] VEC_LAST = 16'h0063;  // last source vector
	localparam logic [15:0] VEC_RSVD = 16'h0053;  // reserved vector
	localparam int CA_RANK_RAISE = 2;  // counter array polling rank raised by two
	localparam int CA_SLOT = 6;  // counter array slot index
	localparam logic [11:0] ENABLE_RESET = 12'h000;  // enables cleared at reset
	localparam logic [3:0] IDX_NONE = 4'hF;  // no winner

	// source order, by vector slot
	typedef enum logic [3:0] {
		SRC_EXT_A, SRC_TMR_A, SRC_EXT_B, SRC_TMR_B, SRC_SERIAL, SRC_TMR_C,
		SRC_CA, SRC_KEYPAD, SRC_TWO_WIRE, SRC_SPI, SRC_RSVD, SRC_COMPARATOR,
		SRC_CONVERTER
	} src_t;

	// ********************************
	// grouped request flags
	// ********************************
	typedef struct packed {
		logic       ext_a_request_flag;
		logic       timer_a_overflow_flag;
		logic       ext_b_request_flag;
		logic       timer_b_overflow_flag;
		logic       serial_receive_flag;
		logic       serial_transmit_flag;
		logic       timer_c_overflow_flag;
		logic       timer_c_external_flag;
		logic       counter_array_overflow_flag;
		logic [4:0] compare_module_flags;
		logic [7:0] keypad_flags;
		logic       two_wire_flag;
		logic       spi_done_flag;
		logic       spi_fault_flag;
		logic       spi_tx_empty_flag;
		logic       comparator_a_flag;
		logic       comparator_b_flag;
		logic       converter_done_flag;
	} flags_t;

	// vector answer towards the core
	typedef struct packed {
		logic        pending;
		logic [3:0]  slot;
		logic [15:0] vector;
	} vec_t;

endpackage

// ---- irq_rank.sv ----
`timescale 1ns/1ns
// picks the winning slot by polling rank among enabled requests
module irq_rank
	import irq_pkg::*;
#(
	parameter int N = NUM_SRC  // number of slots
) (
	input  wire logic [N-1:0] req_in,   // gated requests per slot
	output logic      [3:0]   win_out,  // winning slot or none
	output logic              any_out   // some request present
);
	// counter array checked ahead of serial and timer c slots [R08] [R03]
	always_comb begin
		win_out = IDX_NONE;
		any_out = |req_in;
		for (int i = N - 1; i >= 0; i--) begin
			if (req_in[i] && i != CA_SLOT) begin
				win_out = 4'(i);  // lowest slot wins [R08]
			end
		end
		if (req_in[CA_SLOT] && !(req_in[0] || req_in[1] || req_in[2] || req_in[3])) begin
			win_out = 4'(CA_SLOT);  // rank 5, behind slot 3, ahead of 4 and 5 [R03]
		end
	end
endmodule

// ---- irq_vector_and_enable.sv ----
`timescale 1ns/1ns
// How it works
// [R01] thirteen vectors eight bytes apart, 0053H reserved
// [R02] reset start 0000H, vectors 0003H to 0063H
// [R03] counter array: overflow or compare, rank five
// [R04] shared vectors request on OR of flags
// [R05] per-source enable bit masks each source
// [R06] global enable cleared blocks all sources
// [R07] software set or clear acts like hardware
// [R08] lower vector wins, counter array up two
// [R09] reset clears every enable bit
module irq_vector_and_enable
	import irq_pkg::*;
(
	input  wire logic        CLK_IN,         // system clock, 25 MHz
	input  wire logic        NRST_IN,        // synchronous reset, active low
	input  wire logic        CE_IN,          // clock enable, freezes state when low
	input  wire flags_t      HW_SET_IN,      // hardware flag set pulses
	input  wire flags_t      HW_CLR_IN,      // hardware flag clear pulses
	input  wire flags_t      SW_SET_IN,      // software flag set pulses
	input  wire flags_t      SW_CLR_IN,      // software flag clear pulses
	input  wire logic        EN_WR_IN,       // write strobe for the enables
	input  wire logic [7:0]  EN_FIRST_IN,    // first enable register, bit 7 global
	input  wire logic [7:0]  EN_SECOND_IN,   // second enable register
	output logic      [7:0]  EN_FIRST_OUT,   // first enable register readback
	output logic      [7:0]  EN_SECOND_OUT,  // second enable register readback
	output flags_t           FLAGS_OUT,      // current request flags
	output vec_t             VEC_OUT,        // pending vector for the core
	output logic      [15:0] START_OUT       // program start after reset
);
	// ********************************
	// state
	// ********************************
	flags_t      flags, next_flags;          // request flags
	logic [7:0]  en_first, next_en_first;    // global plus first enables
	logic [7:0]  en_second, next_en_second;  // second enables
	vec_t        next_vec;                   // answer for the next edge
	logic [NUM_SRC-1:0] req;                 // OR-ed requests per slot
	logic [NUM_SRC-1:0] gated;               // after enables
	logic [NUM_SRC-1:0] en_bits;             // enables per slot
	logic [3:0]  win;                        // winning slot
	logic        any;                        // something enabled is pending

	// ********************************
	// flag update
	// ********************************
	// set wins over clear so an event at the clear cycle is kept [R07]
	// software and hardware pulses merge here, so neither path is privileged;
	// a routine that clears a flag in the cycle of a new event sees it again,
	// which is the safe side: an event is never lost, at worst served twice
	always_comb begin
		next_flags = (flags & ~(HW_CLR_IN | SW_CLR_IN)) | HW_SET_IN | SW_SET_IN;  // [R07]
	end

	// enables load on the write strobe only
	// both registers load together, so a write must carry both values
	always_comb begin
		next_en_first  = en_first;   // hold by default
		next_en_second = en_second;  // hold by default
		if (EN_WR_IN) begin          // new enables act on the answer one edge later
			next_en_first  = EN_FIRST_IN;
			next_en_second = EN_SECOND_IN;
		end
	end

	// ********************************
	// request per slot
	// ********************************
	// shared vectors OR their flags [R04]; counter array ORs six [R03]
	always_comb begin
		req = '0;
		req[SRC_EXT_A]      = flags.ext_a_request_flag;
		req[SRC_TMR_A]      = flags.timer_a_overflow_flag;
		req[SRC_EXT_B]      = flags.ext_b_request_flag;
		req[SRC_TMR_B]      = flags.timer_b_overflow_flag;
		req[SRC_SERIAL]     = flags.serial_receive_flag | flags.serial_transmit_flag;  // [R04]
		req[SRC_TMR_C]      = flags.timer_c_overflow_flag | flags.timer_c_external_flag;  // [R04]
		req[SRC_CA]         = flags.counter_array_overflow_flag
		                    | (|flags.compare_module_flags);  // [R03]
		req[SRC_KEYPAD]     = |flags.keypad_flags;
		req[SRC_TWO_WIRE]   = flags.two_wire_flag;
		req[SRC_SPI]        = flags.spi_done_flag | flags.spi_fault_flag
		                    | flags.spi_tx_empty_flag;  // [R04]
		req[SRC_COMPARATOR] = flags.comparator_a_flag | flags.comparator_b_flag;  // [R04]
		req[SRC_CONVERTER]  = flags.converter_done_flag;  // last vector slot [R02]
		// the reserved slot keeps the zero of the default above [R01]
	end

	// enables: first reg bits 6..0 for slots 6..0, second reg for the rest
	// second reg bits 2..0 feed slots 9..7 and bits 4..3 feed slots 12..11;
	// bits 7..5 of the second reg are stored but gate nothing
	always_comb begin
		en_bits = {en_second[4:3], 1'b0, en_second[2:0], en_first[6:0]};  // [R05]
		en_bits[SLOT_RESERVED] = 1'b0;  // reserved slot never vectors [R01]
		// the global bit is applied last so it overrides every source bit
		gated = req & en_bits & {NUM_SRC{en_first[7]}};  // [R05] [R06]
	end

	// ranking is pure logic; its result is registered with the answer below,
	// so the core sees the winner of the registered flags one edge after they are stored
	irq_rank #(
		.N(NUM_SRC)
	) u_rank (
		.req_in (gated),
		.win_out(win),
		.any_out(any)
	);

	// slot index to address, eight bytes apart [R01]
	// with nothing pending the vector reads as the reset address, never
	// as a stale slot that the core could mistake for a request
	always_comb begin
		next_vec.pending = any;
		next_vec.slot    = win;
		next_vec.vector  = any ? VEC_FIRST + VEC_STEP * {12'h000, win} : VEC_RESET;  // [R01]
	end

	// ********************************
	// registers
	// ********************************
	// reset clears flags and every enable [R09]
	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN) begin
			flags     <= '0;
			en_first  <= ENABLE_RESET[7:0];  // [R09]
			en_second <= ENABLE_RESET[7:0];  // [R09]
			START_OUT <= VEC_RESET;  // [R02]
		end else if (CE_IN) begin  // clock enable low freezes everything
			flags     <= next_flags;
			en_first  <= next_en_first;
			en_second <= next_en_second;
			START_OUT <= VEC_RESET;  // constant start address
		end
	end

	// outputs mirror the state from their own flops, so every port comes
	// straight from a register; the cost is a second copy of the state

	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN) begin
			EN_FIRST_OUT  <= '0;
			EN_SECOND_OUT <= '0;
			FLAGS_OUT     <= '0;
			VEC_OUT       <= '0;
		end else if (CE_IN) begin
			EN_FIRST_OUT  <= next_en_first;
			EN_SECOND_OUT <= next_en_second;
			FLAGS_OUT     <= next_flags;
			VEC_OUT       <= next_vec;
		end
	end

	// ********************************
	// checks
	// ********************************
	// the answer is built from the enables already registered, so these
	// guards on the answer look at the stored enables and never at the write data
	a_global_blocks: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)  // [R06]
		CE_IN && !en_first[7] |=> !VEC_OUT.pending)
		else $error("pending with global enable off");
	a_mask_blocks: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)  // [R05]
		CE_IN && !en_second[0] |=> VEC_OUT.slot != 4'(SRC_KEYPAD))
		else $error("masked source vectored");
	a_enable_load: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)  // [R05]
		CE_IN && EN_WR_IN |=> EN_FIRST_OUT == $past(EN_FIRST_IN)
		&& EN_SECOND_OUT == $past(EN_SECOND_IN))
		else $error("enable write not loaded");
	a_reset_enables: assert property (@(posedge CLK_IN)  // [R09] [R02]
		!NRST_IN |=> EN_FIRST_OUT == 8'h00 && EN_SECOND_OUT == 8'h00
		&& START_OUT == VEC_RESET)
		else $error("enables not cleared by reset");

	// ********************************
	// checks: vectors and ranking
	// ********************************
	// range checks catch a slot index that runs past the table
	a_vector_range: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)  // [R01]
		VEC_OUT.pending |-> VEC_OUT.vector >= VEC_FIRST && VEC_OUT.vector <= VEC_LAST
		&& VEC_OUT.vector != VEC_RSVD)
		else $error("vector out of range");
	a_reserved_idle: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)  // [R01]
		VEC_OUT.pending |-> VEC_OUT.slot != 4'(SLOT_RESERVED))
		else $error("reserved slot vectored");
	a_converter_last: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)  // [R02]
		CE_IN && gated[SRC_CONVERTER] && gated[11:0] == 12'h000
		|=> VEC_OUT.pending && VEC_OUT.vector == VEC_LAST)
		else $error("last vector not reached");
	a_low_wins: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)  // [R08]
		gated[SRC_EXT_A] && CE_IN |=> VEC_OUT.vector == VEC_FIRST)
		else $error("lowest vector not chosen");
	a_ca_rank: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)  // [R03] [R08]
		gated[CA_SLOT] && gated[SRC_SERIAL] && gated[3:0] == 4'h0 && CE_IN
		|=> VEC_OUT.slot == 4'(CA_SLOT))
		else $error("counter array lost rank");
	a_ca_request: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)  // [R03]
		CE_IN && (|flags.compare_module_flags) && en_first[7] && en_first[6]
		&& gated[3:0] == 4'h0 |=> VEC_OUT.pending && VEC_OUT.vector == 16'h0033)
		else $error("compare flag not vectored");
	// only the counter array and slots 0 to 3 may beat the serial slot
	a_shared_or: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)  // [R04]
		CE_IN && en_first[7] && en_first[4] && !gated[CA_SLOT]
		&& (flags.serial_receive_flag || flags.serial_transmit_flag)
		&& gated[3:0] == 4'h0 |=> VEC_OUT.vector == 16'h0023)
		else $error("serial OR not vectored");

	// ********************************
	// checks: flags and freeze
	// ********************************
	// one flag of each kind stands for all, the update is the same per bit
	a_set_wins: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)  // [R07]
		CE_IN && SW_SET_IN.spi_done_flag && SW_CLR_IN.spi_done_flag
		|=> FLAGS_OUT.spi_done_flag)
		else $error("set lost to clear");
	a_hw_set_flag: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)  // [R07]
		CE_IN && HW_SET_IN.keypad_flags[0] |=> FLAGS_OUT.keypad_flags[0])
		else $error("hardware set lost");
	a_clear_drops: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)  // [R07]
		CE_IN && SW_CLR_IN.converter_done_flag && !SW_SET_IN.converter_done_flag
		&& !HW_SET_IN.converter_done_flag |=> !FLAGS_OUT.converter_done_flag)
		else $error("software clear lost");
	a_freeze_hold: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
		!CE_IN |=> $stable(VEC_OUT) && $stable(FLAGS_OUT)
		&& $stable(EN_FIRST_OUT) && $stable(EN_SECOND_OUT))
		else $error("state moved with clock enable low");
endmodule

// ---- core_model.sv ----
`timescale 1ns/1ns
// core side: takes a pending vector only on the last cycle of an instruction, samples the address every cycle
module core_model
	import irq_pkg::*;
#(
	parameter int POLL = 3  // cycles per instruction, slow core when larger
) (
	input  wire logic        clk,     // system clock
	input  wire vec_t        vec_in,  // vector answer from the block
	output logic             got,     // a vector was taken this cycle
	output logic      [15:0] addr     // vector address taken
);
	int cnt = 0;  // cycle within the current instruction
	// polling on every cycle would hide a late vector, so poll once per instruction
	always @(posedge clk) begin
		cnt <= (cnt + 1) % POLL;
		got <= (cnt == POLL - 1) && vec_in.pending;
		addr <= vec_in.vector;
	end
endmodule

// ---- irq_vector_and_enable_tb.sv ----
`timescale 1ns/1ns
`define CHK(w, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
	$display("mismatch %s exp %h got %h", w, e, g); end end
module irq_vector_and_enable_tb;
	import irq_pkg::*;
	// ********************************
	// stimulus, outputs and model state
	// ********************************
	logic        clk = 0, nrst = 0, ce = 1, en_wr = 0;  // control inputs
	flags_t      hs = '0, hc = '0, ss = '0, sc = '0;     // set and clear pulses
	logic [7:0]  e1 = 8'h00, e2 = 8'h00, q1, q2;         // enables in and back
	flags_t      fl, m_fl;                               // flags seen and modelled
	logic [7:0]  m_e1, m_e2;                             // modelled enables
	vec_t        vq, m_vec;                              // vector seen and modelled
	logic [15:0] st, caddr;                              // start address, core fetch
	logic        cgot;                                   // core took a vector
	int          n_errors = 0, comparisons = 0, cyc = 0;
	logic [31:0] seed = 32'h0000003B;                    // lfsr state
	function automatic flags_t rnd();
		repeat (32) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return flags_t'(seed[28:0]);
	endfunction
	// gated requests per slot, slot = (vector - 3) / 8, reserved slot 10 never asks
	function automatic vec_t pick(flags_t f, logic [7:0] a, logic [7:0] b);
		logic [12:0] r;
		int ord [12] = '{0, 1, 2, 3, 6, 4, 5, 7, 8, 9, 11, 12};
		r = {f.converter_done_flag, f.comparator_a_flag | f.comparator_b_flag, 1'b0,
			f.spi_done_flag | f.spi_fault_flag | f.spi_tx_empty_flag, f.two_wire_flag,
			|f.keypad_flags, f.counter_array_overflow_flag | (|f.compare_module_flags),
			f.timer_c_overflow_flag | f.timer_c_external_flag,
			f.serial_receive_flag | f.serial_transmit_flag, f.timer_b_overflow_flag,
			f.ext_b_request_flag, f.timer_a_overflow_flag, f.ext_a_request_flag};
		r = r & {b[4:3], 1'b0, b[2:0], a[6:0]} & {13{a[7]}};
		foreach (ord[i]) if (r[ord[i]]) return '{1'b1, 4'(ord[i]), 16'(3 + 8 * ord[i])};
		return '0;
	endfunction
	task automatic summarize();
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	irq_vector_and_enable u_dut (.CLK_IN(clk), .NRST_IN(nrst), .CE_IN(ce), .HW_SET_IN(hs),
		.HW_CLR_IN(hc), .SW_SET_IN(ss), .SW_CLR_IN(sc), .EN_WR_IN(en_wr), .EN_FIRST_IN(e1),
		.EN_SECOND_IN(e2), .EN_FIRST_OUT(q1), .EN_SECOND_OUT(q2), .FLAGS_OUT(fl),
		.VEC_OUT(vq), .START_OUT(st));
	core_model #(.POLL(3)) u_core (.clk(clk), .vec_in(vq), .got(cgot), .addr(caddr));
	// ********************************
	// clock, random drive and model
	// ********************************
	initial forever #20 clk = ~clk;
	// sparse pulses keep flags mixed; clock enable drops now and then to test the freeze
	always @(posedge clk) begin
		hs <= rnd() & rnd() & rnd();
		hc <= rnd() & rnd() & rnd();
		ss <= rnd() & rnd() & rnd();
		sc <= rnd() & rnd() & rnd();
		en_wr <= seed[2:0] == 3'h0;
		ce <= seed[7:4] != 4'h0;
		e1 <= seed[15:8];
		e2 <= seed[23:16];
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			n_errors++;
			summarize();
		end
	end
	// model: set beats clear, vector follows registered flags one edge later
	always @(posedge clk) begin
		if (!nrst) begin
			m_fl <= '0;
			m_e1 <= 8'h00;
			m_e2 <= 8'h00;
			m_vec <= '0;
		end else if (ce) begin
			m_fl <= (m_fl & ~(hc | sc)) | hs | ss;
			if (en_wr) begin
				m_e1 <= e1;
				m_e2 <= e2;
			end
			m_vec <= pick(m_fl, m_e1, m_e2);
		end
	end
	// compare on the falling edge, where all outputs have settled
	always @(negedge clk) if (cyc > 1) begin
		`CHK("flags", m_fl, fl)
		`CHK("en_first", m_e1, q1)
		`CHK("en_second", m_e2, q2)
		`CHK("pending", m_vec.pending, vq.pending)
		`CHK("vector", m_vec.vector, vq.vector)
		if (m_vec.pending) `CHK("slot", m_vec.slot, vq.slot)
		`CHK("start", 16'h0000, st)
		if (cgot === 1'b1) `CHK("fetch", 1'b1, caddr != 16'h0053 && caddr[2:0] == 3'h3)
	end
	// ********************************
	// sequence: reset, random run, reset in mid-run, random run
	// ********************************
	initial begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		repeat (3000) @(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		repeat (1000) @(posedge clk);
		summarize();
	end
endmodule
